// file: hdl/seq_pkg.sv
// package for the boot strap and power sequencer
// assumes a 20 MHz system clock
package seq_pkg;

  localparam int unsigned CLK_HZ        = 20000000;
  localparam int unsigned STRAP_WIN_MS  = 2;
  localparam int unsigned RAIL3_DLY_MS  = 13;
  localparam int unsigned PGOOD_DLY_MS  = 75;
  localparam int unsigned DISCH_DLY_MS  = 1;
  localparam int unsigned FILT_LEN      = 4;
  localparam int unsigned STRAP_CYC     = STRAP_WIN_MS * (CLK_HZ / 1000);
  localparam int unsigned RAIL3_CYC     = RAIL3_DLY_MS * (CLK_HZ / 1000);
  localparam int unsigned PGOOD_CYC     = PGOOD_DLY_MS * (CLK_HZ / 1000);
  localparam int unsigned DISCH_CYC     = DISCH_DLY_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W         = 24;
  localparam int unsigned FILT_W        = 3;

  typedef enum logic [1:0] {
    BOOT_NAND,
    BOOT_USB_REC
  } boot_mode_t;

  typedef struct packed {
    logic supplyOk;
    logic powerEnable;
    logic bootSelectStrapN;
    logic runPowerGoodIn;
    logic watchdogExpired;
  } pins_in_t;

  typedef struct packed {
    logic supplyOut3v3;
    logic supplyOut1v8;
    logic runPowerGood;
    logic runPowerGoodOe;
    logic externalResetOutN;
    logic socResetN;
    logic emmcResetN;
    logic usbDeviceMode;
    logic recoveryMode;
    logic nandBoot;
  } pins_out_t;

endpackage

// file: hdl/input_sync.sv
// two flop synchroniser with a short glitch filter
// assumes one clock domain, asynchronous active low reset
`timescale 1ns/1ns
`default_nettype none
module input_sync
  import seq_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic nrst,
  // data
  input  wire logic asyncIn,
  output var  logic syncOut
);

  logic             meta_reg;
  logic             stage_reg;
  logic             out_reg;
  logic [FILT_W-1:0] cnt_reg;
  logic             out_next;
  logic [FILT_W-1:0] cnt_next;

  // filter: accept a change after it stays stable
  always_comb begin
    out_next = out_reg;
    cnt_next = '0;
    if (stage_reg != out_reg) begin
      if (cnt_reg == FILT_W'(FILT_LEN - 1)) begin
        out_next = stage_reg;
      end else begin
        cnt_next = cnt_reg + FILT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg  <= RESET_VAL;
      stage_reg <= RESET_VAL;
      out_reg   <= RESET_VAL;
      cnt_reg   <= '0;
    end else begin
      meta_reg  <= asyncIn;
      stage_reg <= meta_reg;
      out_reg   <= out_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign syncOut = out_reg;

endmodule // input_sync
`default_nettype wire

// file: hdl/boot_strap_power_sequencer.sv
// boot mode selection and power/reset sequencing of the module
// assumes pin inputs are asynchronous; rails are enables to regulators
//
// Overview of operation
// (R01) normal boot from 64 MB serial NAND; eMMC or card holds the system
// (R02) strap low at power-on selects USB recovery instead of normal boot
// (R03) strap low at reset release: USB pair becomes device, recovery mode
// (R04) strap pulled high internally; floating reads high, normal boot
// (R05) carrier drives strap low within 2 ms of 5 V rising
// (R06) power-up starts only with 5 V above 4.8 V and enable high
// (R07) enable is delayed internally so it rises after 5 V; here enable is only filtered like 5 V, with no added delay
// (R08) carrier keeps enable high while module should stay powered
// (R09) 3.3 V rail rises at least 13 ms after 5 V rises
// (R10) power-good rises at least 75 ms after 3.3 V rail
// (R11) power-good stays high after bring-up completes
// (R12) carrier pulling power-good low resets only SoC and eMMC
// (R13) power-good released high when sequence completes
// (R14) enable low powers module off to lowest-power state
// (R15) watchdog timeout asserts active-low external reset output
// (R16) shutdown discharges 1.8 V rail before 3.3 V rail
// (R17) power-good low while enable low or delays pending; restart counting
`timescale 1ns/1ns
`default_nettype none
module boot_strap_power_sequencer
  import seq_pkg::*;
#(
  // divides every delay; 1 in silicon, larger only to shorten runs
  parameter int unsigned TIME_DIV = 1
) (
  // clock and reset
  input  wire logic      sys_clk,
  input  wire logic      nrst,
  // pins
  input  wire pins_in_t  pinsIn,
  output var  pins_out_t pinsOut
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic supplyOk;
  logic powerEnable;
  logic strapN;
  logic pgIn;
  logic wdog;

  input_sync #(.RESET_VAL(1'b0)) uSupply (.sys_clk(sys_clk), .nrst(nrst),
    .asyncIn(pinsIn.supplyOk), .syncOut(supplyOk));
  // enable filtered over the same cycles as 5 V, so no internal delay behind it
  input_sync #(.RESET_VAL(1'b0)) uEnable (.sys_clk(sys_clk), .nrst(nrst),
    .asyncIn(pinsIn.powerEnable), .syncOut(powerEnable)); // see (R07)
  // undriven strap seen as high by the pull-up
  input_sync #(.RESET_VAL(1'b1)) uStrap (.sys_clk(sys_clk), .nrst(nrst),
    .asyncIn(pinsIn.bootSelectStrapN), .syncOut(strapN)); // see (R04)
  input_sync #(.RESET_VAL(1'b0)) uPgIn (.sys_clk(sys_clk), .nrst(nrst),
    .asyncIn(pinsIn.runPowerGoodIn), .syncOut(pgIn));
  input_sync #(.RESET_VAL(1'b0)) uWdog (.sys_clk(sys_clk), .nrst(nrst),
    .asyncIn(pinsIn.watchdogExpired), .syncOut(wdog));

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  localparam int unsigned STRAP_LIM = STRAP_CYC / TIME_DIV;
  localparam int unsigned RAIL3_LIM = RAIL3_CYC / TIME_DIV;
  localparam int unsigned PGOOD_LIM = PGOOD_CYC / TIME_DIV;
  localparam int unsigned DISCH_LIM = DISCH_CYC / TIME_DIV;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_WAIT_3V3,
    ST_WAIT_PG,
    ST_RUN,
    ST_DISCH_1V8,
    ST_DISCH_3V3
  } seq_state_t;

  seq_state_t       state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [CNT_W-1:0] strapCnt_reg, strapCnt_next;
  logic             strapLow_reg, strapLow_next;
  boot_mode_t       mode_reg, mode_next;
  pins_out_t        out_reg, out_next;
  logic             powerUp;

  assign powerUp = supplyOk && powerEnable; // see (R06)

  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    strapCnt_next = strapCnt_reg;
    strapLow_next = strapLow_reg;
    mode_next     = mode_reg;
    // strap window counted from 5 V rising
    if (!supplyOk) begin
      strapCnt_next = '0;
      strapLow_next = 1'b0;
    end else if (strapCnt_reg < CNT_W'(STRAP_LIM)) begin
      strapCnt_next = strapCnt_reg + CNT_W'(1);
      if (!strapN) begin
        strapLow_next = 1'b1; // see (R02) (R05)
      end
    end
    case (state_reg)
      ST_OFF: begin
        cnt_next = '0; // see (R17)
        if (supplyOk) begin
          cnt_next = (cnt_reg < CNT_W'(RAIL3_LIM)) ? cnt_reg + CNT_W'(1) : cnt_reg;
        end
        if (powerUp) begin
          state_next = ST_WAIT_3V3;
        end
      end
      ST_WAIT_3V3: begin
        cnt_next = cnt_reg + CNT_W'(1);
        if (!powerUp) begin
          state_next = ST_DISCH_1V8; // see (R14)
          cnt_next   = '0;
        end else if (cnt_reg >= CNT_W'(RAIL3_LIM)) begin
          state_next = ST_WAIT_PG; // see (R09)
          cnt_next   = '0;
        end
      end
      ST_WAIT_PG: begin
        cnt_next = cnt_reg + CNT_W'(1);
        if (!powerUp) begin
          state_next = ST_DISCH_1V8;
          cnt_next   = '0;
        end else if (cnt_reg >= CNT_W'(PGOOD_LIM)) begin
          state_next = ST_RUN; // see (R10) (R13)
          // strap decision taken as reset releases
          mode_next  = (strapLow_reg || !strapN) ? BOOT_USB_REC : BOOT_NAND; // see (R03)
        end
      end
      ST_RUN: begin
        cnt_next = '0;
        if (!powerUp) begin
          state_next = ST_DISCH_1V8; // see (R11) (R14)
        end
      end
      ST_DISCH_1V8: begin
        cnt_next = cnt_reg + CNT_W'(1);
        if (cnt_reg >= CNT_W'(DISCH_LIM)) begin
          state_next = ST_DISCH_3V3; // see (R16)
          cnt_next   = '0;
        end
      end
      ST_DISCH_3V3: begin
        cnt_next   = '0;
        state_next = ST_OFF;
      end
      default: begin
        state_next = ST_OFF;
        cnt_next   = '0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // output drive
  // ---------------------------------------------------------------
  always_comb begin
    out_next                   = '0;
    out_next.externalResetOutN = 1'b1;
    case (state_next)
      ST_WAIT_3V3: begin
        out_next.supplyOut3v3 = 1'b0;
      end
      ST_WAIT_PG: begin
        out_next.supplyOut3v3 = 1'b1;
        out_next.supplyOut1v8 = 1'b1;
      end
      ST_DISCH_1V8: begin
        // 3.3 V kept as it was, so an aborted start never lights it
        out_next.supplyOut3v3 = out_reg.supplyOut3v3; // see (R16)
        out_next.supplyOut1v8 = 1'b0;
      end
      ST_RUN: begin
        out_next.supplyOut3v3   = 1'b1;
        out_next.supplyOut1v8   = 1'b1;
        out_next.runPowerGood   = 1'b1; // see (R13)
        out_next.runPowerGoodOe = 1'b1;
        // carrier low on power-good resets only SoC and eMMC
        out_next.socResetN      = pgIn; // see (R12)
        out_next.emmcResetN     = pgIn && !wdog;
        out_next.externalResetOutN = !wdog; // see (R15)
        out_next.usbDeviceMode  = (mode_next == BOOT_USB_REC); // see (R03)
        out_next.recoveryMode   = (mode_next == BOOT_USB_REC);
        out_next.nandBoot       = (mode_next == BOOT_NAND); // see (R01)
      end
      default: begin
        out_next.supplyOut3v3 = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= ST_OFF;
      cnt_reg      <= '0;
      strapCnt_reg <= '0;
      strapLow_reg <= 1'b0;
      mode_reg     <= BOOT_NAND;
      out_reg      <= '{externalResetOutN: 1'b1, default: 1'b0};
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      strapCnt_reg <= strapCnt_next;
      strapLow_reg <= strapLow_next;
      mode_reg     <= mode_next;
      out_reg      <= out_next;
    end
  end

  assign pinsOut = out_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] railAge_reg;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      railAge_reg <= '0;
    end else begin
      railAge_reg <= out_reg.supplyOut3v3 ? railAge_reg + CNT_W'(1) : '0;
    end
  end

  a_pg_after_rail: assert property (@(posedge sys_clk) disable iff (!nrst) // see (R10)
    $rose(out_reg.runPowerGood) |-> railAge_reg >= CNT_W'(PGOOD_LIM))
    else $error("power-good rose too early after 3.3 V");
  a_pg_needs_enable: assert property (@(posedge sys_clk) disable iff (!nrst) // see (R17)
    !powerUp |=> !out_reg.runPowerGood)
    else $error("power-good high without enable");
  a_rail_after_supply: assert property (@(posedge sys_clk) disable iff (!nrst) // see (R09)
    $rose(out_reg.supplyOut3v3) |-> $past(cnt_reg) >= CNT_W'(RAIL3_LIM))
    else $error("3.3 V rail rose too early");
  a_disch_order: assert property (@(posedge sys_clk) disable iff (!nrst) // see (R16)
    $fell(out_reg.supplyOut3v3) |-> !out_reg.supplyOut1v8 && $past(!out_reg.supplyOut1v8))
    else $error("1.8 V not discharged before 3.3 V");
  a_off_on_enable: assert property (@(posedge sys_clk) disable iff (!nrst) // see (R14)
    !powerUp ##1 !powerUp[*2] |=> !out_reg.supplyOut1v8)
    else $error("1.8 V rail still on with enable low");
  a_wdog_reset: assert property (@(posedge sys_clk) disable iff (!nrst) // see (R15)
    wdog && state_next == ST_RUN |=> !out_reg.externalResetOutN)
    else $error("watchdog did not reset peripherals");
  a_rec_mode: assert property (@(posedge sys_clk) disable iff (!nrst) // see (R03)
    out_reg.recoveryMode |-> out_reg.usbDeviceMode && !out_reg.nandBoot)
    else $error("recovery without USB device mode");
  a_pg_holds: assert property (@(posedge sys_clk) disable iff (!nrst) // see (R11)
    out_reg.runPowerGood && powerUp |=> out_reg.runPowerGood)
    else $error("power-good dropped while powered");
  a_soc_reset: assert property (@(posedge sys_clk) disable iff (!nrst) // see (R12)
    state_reg == ST_RUN && state_next == ST_RUN && !pgIn |=> !out_reg.socResetN)
    else $error("carrier reset not passed to SoC");

  c_run: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(out_reg.runPowerGood));
  c_recovery: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(out_reg.recoveryMode));
  c_shutdown: cover property (@(posedge sys_clk) disable iff (!nrst) $fell(out_reg.supplyOut3v3));
  c_wdog: cover property (@(posedge sys_clk) disable iff (!nrst) $fell(out_reg.externalResetOutN));

endmodule // boot_strap_power_sequencer
`default_nettype wire

// file: sim/carrier_model.sv
// carrier board model: 5 V supply, enable with rc delay, strap, reset wire
// assumes the bench commands it and reads the sequencer's outputs
`timescale 1ns/1ns
`default_nettype none
module carrier_model
  import seq_pkg::*;
#(
  parameter int EN_DLY = 200
) (
  // clock
  input  wire logic      sys_clk,
  // bench commands
  input  wire logic      powerOn,
  input  wire logic      holdOff,
  input  wire logic      strapLow,
  input  wire logic      pullPgLow,
  input  wire logic      watchdog,
  // module pins
  input  wire pins_out_t pinsOut,
  output var  pins_in_t  pinsIn
);
  int enCnt = 0;

  // enable lags the supply like an rc network
  always @(posedge sys_clk) begin
    enCnt <= powerOn ? ((enCnt < EN_DLY) ? enCnt + 1 : enCnt) : 0;
  end

  always_comb begin
    pinsIn.supplyOk         = powerOn;
    pinsIn.powerEnable      = powerOn && !holdOff && (enCnt >= EN_DLY);
    pinsIn.bootSelectStrapN = !strapLow;
    // wire low unless the module drives it high and the carrier lets go
    pinsIn.runPowerGoodIn   = !pullPgLow && pinsOut.runPowerGoodOe
                              && pinsOut.runPowerGood;
    pinsIn.watchdogExpired  = watchdog;
  end
endmodule // carrier_model
`default_nettype wire

// file: sim/tb.sv
// self-checking bench for the boot strap and power sequencer
// assumes the carrier model drives every pin input
`timescale 1ns/1ns
`default_nettype none
module tb
  import seq_pkg::*;
;
  localparam int        TMO  = 80000;
  // delays shortened by DIV so the run stays short
  localparam int        DIV   = 100;
  localparam int        RAIL3 = int'(RAIL3_CYC / DIV);
  localparam int        PGOOD = int'(PGOOD_CYC / DIV);
  localparam int        DISCH = int'(DISCH_CYC / DIV);
  localparam pins_out_t OFFV = 10'h020;

  logic      sys_clk    = 1'b0;
  logic      nrst       = 1'b0;
  logic      powerOn    = 1'b0;
  logic      holdOff    = 1'b0;
  logic      strapLow   = 1'b0;
  logic      pullPgLow  = 1'b0;
  logic      watchdog   = 1'b0;
  pins_in_t  pinsIn;
  pins_out_t pinsOut;
  int        fails      = 0;
  int        n_compared = 0;
  int        cycles     = 0;
  int        n;
  int        t0;

  always #25 sys_clk = ~sys_clk;

  boot_strap_power_sequencer #(.TIME_DIV(DIV)) u_boot_strap_power_sequencer (
    .sys_clk (sys_clk), .nrst (nrst), .pinsIn (pinsIn), .pinsOut (pinsOut));

  carrier_model u_carrier_model (
    .sys_clk (sys_clk), .powerOn (powerOn), .holdOff (holdOff), .strapLow (strapLow),
    .pullPgLow (pullPgLow), .watchdog (watchdog), .pinsOut (pinsOut), .pinsIn (pinsIn));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic expExt(input logic wd);
    return !wd;
  endfunction

  task automatic chk(input logic got, input logic exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  // bounded wait for one output bit, count left in n
  task automatic waitFor(input int b, input logic lvl, input int lim, input string msg);
    n = 0;
    while (pinsOut[b] !== lvl && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
    chk(pinsOut[b], lvl, msg);
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == TMO) begin
      fails++;
      $display("BAD %0t timeout", $time);
      report_and_stop();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hd429));
    repeat (15) @(negedge sys_clk);
    chk(pinsOut === OFFV, 1'b1, "reset state");
    @(negedge sys_clk);
    nrst = 1'b1;
    $display("test reset done");
    // power-up dropped before the 3.3 V delay ends
    powerOn = 1'b1;
    t0 = 200 + $urandom % 2000;
    repeat (t0) @(negedge sys_clk);
    chk(pinsOut.supplyOut3v3, 1'b0, "3v3 early");
    powerOn = 1'b0;
    repeat (40) @(negedge sys_clk);
    chk(pinsOut === OFFV, 1'b1, "abort not off");
    $display("test abort done");
    // recovery boot, strap low inside the 2 ms window
    powerOn = 1'b1;
    t0 = 20 + $urandom % 300;
    repeat (t0) @(negedge sys_clk);
    strapLow = 1'b1;
    waitFor(9, 1'b1, RAIL3 + DISCH + 500 - t0, "3v3 rise");
    chk(n + t0 >= RAIL3, 1'b1, "3v3 too soon");
    strapLow = 1'b0;
    waitFor(7, 1'b1, PGOOD + 100, "pg rise");
    chk(n >= PGOOD, 1'b1, "pg too soon");
    repeat (20) @(negedge sys_clk);
    chk(pinsOut.recoveryMode, 1'b1, "no recovery");
    chk(pinsOut.usbDeviceMode, 1'b1, "usb not device");
    chk(pinsOut.nandBoot, 1'b0, "nand in recovery");
    chk(pinsOut.runPowerGoodOe, 1'b1, "pg not driven");
    chk(pinsOut.socResetN, 1'b1, "soc held");
    $display("test recovery done");
    for (int i = 0; i < 8; i++) begin
      watchdog = (i == 0) | 1'($urandom % 2);
      repeat (20 + $urandom % 20) @(negedge sys_clk);
      chk(pinsOut.externalResetOutN, expExt(watchdog), "ext reset");
      chk(pinsOut.runPowerGood, 1'b1, "pg dropped");
    end
    watchdog = 1'b0;
    pullPgLow = 1'b1;
    repeat (20) @(negedge sys_clk);
    chk(pinsOut.socResetN, 1'b0, "soc not reset");
    chk(pinsOut.emmcResetN, 1'b0, "emmc not reset");
    chk(pinsOut.supplyOut3v3, 1'b1, "rail hit by reset");
    chk(pinsOut.externalResetOutN, 1'b1, "ext hit by reset");
    pullPgLow = 1'b0;
    repeat (20) @(negedge sys_clk);
    chk(pinsOut.socResetN, 1'b1, "soc stuck");
    $display("test run done");
    // enable low: 1.8 V first, then 3.3 V
    holdOff = 1'b1;
    waitFor(8, 1'b0, 100, "1v8 off");
    chk(pinsOut.supplyOut3v3, 1'b1, "3v3 not last");
    chk(pinsOut.runPowerGood, 1'b0, "pg high off");
    waitFor(9, 1'b0, DISCH + 100, "3v3 off");
    chk(n >= DISCH, 1'b1, "gap short");
    repeat (5) @(negedge sys_clk);
    chk(pinsOut === OFFV, 1'b1, "not off");
    powerOn = 1'b0;
    holdOff = 1'b0;
    nrst = 1'b0;
    repeat (3) @(negedge sys_clk);
    nrst = 1'b1;
    chk(pinsOut === OFFV, 1'b1, "reset 2 state");
    $display("test shutdown done");
    // normal boot with the strap left to its pull-up
    powerOn = 1'b1;
    waitFor(7, 1'b1, RAIL3 + PGOOD + 1000, "pg rise 2");
    chk(n >= RAIL3 + PGOOD, 1'b1, "restart short");
    chk(pinsOut.nandBoot, 1'b1, "no nand boot");
    chk(pinsOut.recoveryMode, 1'b0, "false recovery");
    chk(pinsOut.usbDeviceMode, 1'b0, "false usb");
    $display("test normal done");
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
